// *** core/cmp_pkg.sv ***
// Overview of operation
// - Counter advances only while run bit set
// - PWM enable bit selects PWM pin mode
// - Clear bit zeroes counter on period match
// - Clock select 000 means undivided clock
// - Level bit B presets pin before match
// - Enable bit A gates flag A interrupt
// - Flags A and B in bits 0,1
// - Counter is a 16-bit up counter
package cmp_pkg;

    // ************************************************************
    // Register indices (byte address is four times the index)
    // ************************************************************
    localparam logic [15:0] IDX_TIMER_MODE = 16'hff80;    // Run and PWM enable
    localparam logic [15:0] IDX_TIMER_CONTROL = 16'hff81; // Clear, clock select, level B
    localparam logic [15:0] IDX_TIMER_IRQ_EN = 16'hff82;  // Interrupt mask
    localparam logic [15:0] IDX_TIMER_FLAGS = 16'hff83;   // Sticky match flags
    localparam logic [15:0] IDX_COUNTER = 16'hff86;       // Counter value
    localparam logic [15:0] IDX_PERIOD = 16'hff88;        // Period compare
    localparam logic [15:0] IDX_DUTY = 16'hff8a;          // Duty compare

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int POS_COUNT_START = 7;       // Mode: counter run
    localparam int POS_PWM_ENABLE = 0;        // Mode: PWM output mode
    localparam int POS_COUNTER_CLEAR = 7;     // Control: clear on period match
    localparam int POS_CLOCK_SELECT_LO = 4;   // Control: select field low bit
    localparam int POS_OUTPUT_LEVEL_B = 1;    // Control: initial pin level
    localparam int POS_MATCH_A = 0;           // Flags and mask: event A
    localparam int POS_MATCH_B = 1;           // Flags and mask: event B

    // ************************************************************
    // Values after reset
    // ************************************************************
    localparam logic [7:0] RST_MODE = 8'h00;
    localparam logic [7:0] RST_CONTROL = 8'h00;
    localparam logic [7:0] RST_IRQ_EN = 8'h00;
    localparam logic [7:0] RST_FLAGS = 8'h00;
    localparam logic [15:0] RST_COUNTER = 16'h0000;
    localparam logic [15:0] RST_PERIOD = 16'hffff;
    localparam logic [15:0] RST_DUTY = 16'h0000;
    localparam logic [6:0] RST_PRESCALE = 7'h00;

    // ************************************************************
    // Bus carrier
    // ************************************************************
    typedef struct packed {
        logic [17:0] adr;   // Byte address
        logic [31:0] dat;   // Write data
        logic [3:0] sel;    // Byte lanes
        logic we;           // Write
        logic cyc;          // Cycle
        logic stb;          // Strobe
    } cmp_wb_req_t;

endpackage : cmp_pkg

// *** core/cmp_prescaler.sv ***
`timescale 1ns/1ps
// ************************************************************
// Clock divider: tick once every 2**select clocks
// ************************************************************
module cmp_prescaler (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [2:0] select_i,
    output logic tick_o
);
    import cmp_pkg::*;

    logic [6:0] div_cnt;       // Free-running divider
    logic [6:0] next_div_cnt;
    logic [6:0] mask;          // Low bits that must be all ones

    // Next divider value and tick decode
    always_comb begin
        next_div_cnt = div_cnt + 7'h01;
        mask = 7'(({7'h00, 1'b1} << select_i) - 8'h01);
        // Select 000 ticks on every clock edge
        tick_o = ((div_cnt & mask) == mask);
    end

    // Divider register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            div_cnt <= RST_PRESCALE;
        end else begin
            div_cnt <= next_div_cnt;
        end
    end

endmodule : cmp_prescaler

// *** core/cmp_timer.sv ***
`timescale 1ns/1ps
// ************************************************************
// Compare-match PWM timer with Wishbone register slave
// ************************************************************
module cmp_timer (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire cmp_pkg::cmp_wb_req_t wb_i,
    output logic wb_ack_o,
    output logic [31:0] wb_dat_o,
    output logic irq_o,
    output logic pwm_output_pin_o
);
    import cmp_pkg::*;

    // ************************************************************
    // Helpers
    // ************************************************************
    // Byte-lane merge of the low lane
    function automatic logic [7:0] merge8(input logic [7:0] old_v, input logic [31:0] wd,
                                          input logic [3:0] sel);
        merge8 = sel[0] ? wd[7:0] : old_v;
    endfunction : merge8

    // Byte-lane merge of the two low lanes
    function automatic logic [15:0] merge16(input logic [15:0] old_v, input logic [31:0] wd,
                                            input logic [3:0] sel);
        merge16 = {sel[1] ? wd[15:8] : old_v[15:8], sel[0] ? wd[7:0] : old_v[7:0]};
    endfunction : merge16

    // ************************************************************
    // State
    // ************************************************************
    logic [7:0] timer_mode;              // Run and PWM enable
    logic [7:0] timer_control;           // Clear, clock select, level B
    logic [7:0] timer_interrupt_enable;  // Mask, same layout as flags
    logic [7:0] timer_event_flags;       // Sticky match flags
    logic [15:0] counter_value;          // Up counter
    logic [15:0] period_compare;         // Compare A
    logic [15:0] duty_compare;           // Compare B
    logic pin;                           // Pin level
    logic ack;                           // Bus answer
    logic [31:0] rdat;                   // Registered read data

    logic [7:0] next_timer_mode;
    logic [7:0] next_timer_control;
    logic [7:0] next_timer_interrupt_enable;
    logic [7:0] next_timer_event_flags;
    logic [15:0] next_counter_value;
    logic [15:0] next_period_compare;
    logic [15:0] next_duty_compare;
    logic next_pin;
    logic next_ack;
    logic [31:0] next_rdat;

    logic tick;        // Counter input clock enable
    logic run;         // Count start bit
    logic pwm_mode;    // PWM output mode
    logic clear_on_a;  // Clear counter on match A
    logic level_b;     // Initial pin level
    logic match_a;     // Counter equals period this tick
    logic match_b;     // Counter equals duty this tick
    logic req;         // Bus request pending
    logic wr;          // Write takes effect this edge
    logic [15:0] idx;  // Register index

    // ************************************************************
    // Clock select divider
    // ************************************************************
    cmp_prescaler u_prescaler (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .select_i(timer_control[POS_CLOCK_SELECT_LO +: 3]),
        .tick_o(tick)
    );

    // Field decode and match events
    always_comb begin
        run = timer_mode[POS_COUNT_START];
        pwm_mode = timer_mode[POS_PWM_ENABLE];
        clear_on_a = timer_control[POS_COUNTER_CLEAR];
        level_b = timer_control[POS_OUTPUT_LEVEL_B];
        // Matches count only on a counting tick, so a stopped timer never fires
        match_a = tick && run && (counter_value == period_compare);
        match_b = tick && run && (counter_value == duty_compare);
        req = wb_i.cyc && wb_i.stb;
        // Write lands on the edge where ack is seen high
        wr = req && wb_i.we && ack;
        idx = wb_i.adr[17:2];
    end

    // ************************************************************
    // Bus slave: ack one cycle after request, then drop
    // ************************************************************
    always_comb begin
        next_ack = req && !ack;
        next_rdat = rdat;
        if (req && !ack) begin
            // Unmapped addresses read as zero and still ack
            unique case (idx)
                IDX_TIMER_MODE: next_rdat = {24'h000000, timer_mode};
                IDX_TIMER_CONTROL: next_rdat = {24'h000000, timer_control};
                IDX_TIMER_IRQ_EN: next_rdat = {24'h000000, timer_interrupt_enable};
                IDX_TIMER_FLAGS: next_rdat = {24'h000000, timer_event_flags};
                IDX_COUNTER: next_rdat = {16'h0000, counter_value};
                IDX_PERIOD: next_rdat = {16'h0000, period_compare};
                IDX_DUTY: next_rdat = {16'h0000, duty_compare};
                default: next_rdat = 32'h00000000;
            endcase
        end
    end

    // ************************************************************
    // Control registers
    // ************************************************************
    always_comb begin
        next_timer_mode = timer_mode;
        next_timer_control = timer_control;
        next_timer_interrupt_enable = timer_interrupt_enable;
        next_period_compare = period_compare;
        next_duty_compare = duty_compare;
        if (wr) begin
            unique case (idx)
                IDX_TIMER_MODE: next_timer_mode = merge8(timer_mode, wb_i.dat, wb_i.sel);
                IDX_TIMER_CONTROL: begin
                    next_timer_control = merge8(timer_control, wb_i.dat, wb_i.sel);
                end
                IDX_TIMER_IRQ_EN: begin
                    next_timer_interrupt_enable = merge8(timer_interrupt_enable, wb_i.dat,
                                                         wb_i.sel);
                end
                // Duty reload each period is the software's job
                IDX_PERIOD: next_period_compare = merge16(period_compare, wb_i.dat, wb_i.sel);
                IDX_DUTY: next_duty_compare = merge16(duty_compare, wb_i.dat, wb_i.sel);
                default: next_timer_mode = timer_mode;
            endcase
        end
    end

    // ************************************************************
    // Flags: set wins over write-one-to-clear
    // ************************************************************
    always_comb begin
        next_timer_event_flags = timer_event_flags;
        if (wr && idx == IDX_TIMER_FLAGS && wb_i.sel[0]) begin
            next_timer_event_flags = timer_event_flags & ~wb_i.dat[7:0];
        end
        if (match_a) begin
            next_timer_event_flags[POS_MATCH_A] = 1'b1;
        end
        if (match_b) begin
            next_timer_event_flags[POS_MATCH_B] = 1'b1;
        end
        // Only two flag bits exist; the rest read as zero
        next_timer_event_flags[7:2] = 6'h00;
    end

    // ************************************************************
    // Counter
    // ************************************************************
    always_comb begin
        next_counter_value = counter_value;
        if (wr && idx == IDX_COUNTER) begin
            // Software write beats counting in the same cycle
            next_counter_value = merge16(counter_value, wb_i.dat, wb_i.sel);
        end else if (match_a && clear_on_a) begin
            next_counter_value = 16'h0000;
        end else if (tick && run) begin
            // Wraps from ffff to 0000 when no clear is set
            next_counter_value = counter_value + 16'h0001;
        end
    end

    // ************************************************************
    // Output pin
    // ************************************************************
    always_comb begin
        next_pin = pin;
        if (wr && idx == IDX_TIMER_CONTROL && wb_i.sel[0]) begin
            // Writing control presets the level before the first match B
            next_pin = wb_i.dat[POS_OUTPUT_LEVEL_B];
        end else if (pwm_mode) begin
            // A wins when both match, so a duty equal to the period keeps the start level
            if (match_a) begin
                next_pin = level_b;
            end else if (match_b) begin
                next_pin = 1'b0;
            end
        end else if (match_b) begin
            // Plain compare mode toggles on match B
            next_pin = !pin;
        end
    end

    // All state registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            timer_mode <= RST_MODE;
            timer_control <= RST_CONTROL;
            timer_interrupt_enable <= RST_IRQ_EN;
            timer_event_flags <= RST_FLAGS;
            counter_value <= RST_COUNTER;
            period_compare <= RST_PERIOD;
            duty_compare <= RST_DUTY;
            pin <= 1'b0;
            ack <= 1'b0;
            rdat <= 32'h00000000;
        end else begin
            timer_mode <= next_timer_mode;
            timer_control <= next_timer_control;
            timer_interrupt_enable <= next_timer_interrupt_enable;
            timer_event_flags <= next_timer_event_flags;
            counter_value <= next_counter_value;
            period_compare <= next_period_compare;
            duty_compare <= next_duty_compare;
            pin <= next_pin;
            ack <= next_ack;
            rdat <= next_rdat;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign wb_ack_o = ack;
    assign wb_dat_o = rdat;
    assign pwm_output_pin_o = pin;
    // Level interrupt from any unmasked flag
    assign irq_o = |(timer_event_flags & timer_interrupt_enable);

    // ************************************************************
    // Assertions
    // ************************************************************
    a_hold_when_stopped: assert property (@(posedge clk_i) disable iff (rst_i)
        !run && !(wr && idx == IDX_COUNTER) |=> $stable(counter_value))
        else $error("counter moved while stopped");

    a_pwm_low_on_b: assert property (@(posedge clk_i) disable iff (rst_i)
        pwm_mode && match_b && !match_a && !wr |=> !pwm_output_pin_o)
        else $error("pin not low after match B");

    a_pwm_restore_a: assert property (@(posedge clk_i) disable iff (rst_i)
        pwm_mode && match_a && !wr |=> pwm_output_pin_o == $past(level_b))
        else $error("pin not restored after match A");

    a_clear_on_a: assert property (@(posedge clk_i) disable iff (rst_i)
        match_a && clear_on_a && !wr |=> counter_value == 16'h0000)
        else $error("counter not cleared on match A");

    a_undivided_tick: assert property (@(posedge clk_i) disable iff (rst_i)
        timer_control[6:4] == 3'b000 |-> tick)
        else $error("undivided select missed a tick");

    a_level_b_preset: assert property (@(posedge clk_i) disable iff (rst_i)
        wr && idx == IDX_TIMER_CONTROL && wb_i.sel[0]
        |=> pwm_output_pin_o == $past(wb_i.dat[1]))
        else $error("pin not preset by level B");

    // A mask write in the match cycle may legally drop the request
    a_irq_from_a: assert property (@(posedge clk_i) disable iff (rst_i)
        match_a && timer_interrupt_enable[0] && !(wr && idx == IDX_TIMER_IRQ_EN) |=> irq_o)
        else $error("no interrupt after enabled match A");

    a_flags_after_reset: assert property (@(posedge clk_i)
        rst_i |=> timer_event_flags == 8'h00 && !irq_o)
        else $error("flags not zero after reset");

    a_count_up_step: assert property (@(posedge clk_i) disable iff (rst_i)
        tick && run && !(match_a && clear_on_a) && !wr
        |=> counter_value == $past(counter_value) + 16'h0001)
        else $error("counter did not step by one");

    // A flag write right after the match may legally clear it
    a_flag_b_sticky: assert property (@(posedge clk_i) disable iff (rst_i)
        match_b ##1 !(wr && idx == IDX_TIMER_FLAGS) |-> timer_event_flags[1] [*2])
        else $error("flag B not set or lost");

    a_ack_one_cycle: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held too long");

endmodule : cmp_timer

// *** test/cmp_filter_model.sv ***
`timescale 1ns/1ps
// ************************************************************
// Low-pass filter in front of the speaker amplifier
// ************************************************************
module cmp_filter_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic pwm_i,
    output logic [7:0] level_o
);
    logic [11:0] acc; // Filter state, 8.4 fixed point

    // First-order smoothing, cutoff far below the pin rate
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            acc <= 12'h000;
        end else begin
            // Bounded by 12'hff0, so no wrap
            acc <= acc - (acc >> 4) + (pwm_i ? 12'h0ff : 12'h000);
        end
    end

    assign level_o = acc[11:4]; // Smoothed level, 8'hff is full scale
endmodule : cmp_filter_model

// *** test/cmp_timer_tb.sv ***
`timescale 1ns/1ps
module cmp_timer_tb;
    import cmp_pkg::*;
    // ************************************************************
    // Signals, counters and the register table
    // ************************************************************
    logic clk_i;
    logic rst_i;
    cmp_wb_req_t wb;
    logic wb_ack_o;
    logic [31:0] wb_dat_o;
    logic irq_o;
    logic pwm_output_pin_o;
    logic [7:0] level; // Filtered pin level
    logic [31:0] rd; // Data of the last read
    int err_total;
    int comparisons;
    int highs; // High samples in a window
    int trans; // Pin changes in a window
    // Row: address, lanes, reset value, write value, read-back
    typedef struct packed {
        logic [17:0] adr;
        logic [3:0] sel;
        logic [15:0] rst;
        logic [15:0] wdat;
        logic [15:0] exp;
    } cmp_row_t;
    cmp_row_t rows [8] = '{
        '{18'h3fe00, 4'h1, 16'(RST_MODE), 16'h0001, 16'h0001},
        '{18'h3fe04, 4'h1, 16'(RST_CONTROL), 16'h0070, 16'h0070},
        '{18'h3fe08, 4'h1, 16'(RST_IRQ_EN), 16'h0001, 16'h0001},
        '{18'h3fe0c, 4'h1, 16'(RST_FLAGS), 16'h0003, 16'h0000},
        '{18'h3fe18, 4'h3, RST_COUNTER, 16'hbeef, 16'hbeef},
        '{18'h3fe20, 4'h3, RST_PERIOD, 16'h1234, 16'h1234},
        '{18'h3fe28, 4'h3, RST_DUTY, 16'h00a5, 16'h00a5},
        '{18'h3fe10, 4'h3, 16'h0000, 16'hffff, 16'h0000}}; // Unmapped hole

    cmp_timer u_dut (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .wb_i(wb),
        .wb_ack_o(wb_ack_o),
        .wb_dat_o(wb_dat_o),
        .irq_o(irq_o),
        .pwm_output_pin_o(pwm_output_pin_o)
    );
    cmp_filter_model u_filter (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .pwm_i(pwm_output_pin_o),
        .level_o(level)
    );

    // ************************************************************
    // Tasks
    // ************************************************************
    // Verdict and end of run
    task automatic close_out();
        $display("Comparisons %0d, mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : close_out

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    // One classic cycle; entered just after a rising edge
    task automatic bus(input logic we, input logic [17:0] adr, input logic [3:0] sel,
                       input logic [15:0] dat);
        int n;
        wb.cyc <= 1'b1;
        wb.stb <= 1'b1;
        wb.we <= we;
        wb.adr <= adr;
        wb.sel <= sel;
        wb.dat <= {16'h0000, dat};
        n = 0;
        // Hold everything until ack is sampled high
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        rd = wb_dat_o;
        wb.cyc <= 1'b0;
        wb.stb <= 1'b0;
        wb.we <= 1'b0;
        if (wb_ack_o !== 1'b1) begin
            err_total++;
            close_out();
        end
        @(posedge clk_i); // Idle cycle between requests
    endtask : bus

    task automatic rdchk(input logic [17:0] adr, input logic [3:0] sel, input logic [15:0] exp);
        bus(1'b0, adr, sel, 16'h0000);
        check(rd, {16'h0000, exp});
    endtask : rdchk

    // Count highs and changes of the pin over n clocks
    task automatic measure(input int n);
        logic prev;
        highs = 0;
        trans = 0;
        prev = pwm_output_pin_o;
        repeat (n) begin
            @(posedge clk_i);
            highs += int'(pwm_output_pin_o === 1'b1);
            trans += int'(pwm_output_pin_o !== prev);
            prev = pwm_output_pin_o;
        end
    endtask : measure

    // ************************************************************
    // Clock, watchdog and main sequence
    // ************************************************************
    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end

    // Any hang ends here as a failure
    initial begin
        repeat (20000) @(posedge clk_i);
        err_total++;
        close_out();
    end

    initial begin
        rst_i = 1'b1;
        wb = '0;
        err_total = 0;
        comparisons = 0;
        repeat (8) @(posedge clk_i);
        check({29'h0, wb_ack_o, irq_o, pwm_output_pin_o}, 32'h0);
        rst_i <= 1'b0;
        @(posedge clk_i);
        // Reset value, write, read-back for every row
        foreach (rows[i]) begin
            rdchk(rows[i].adr, rows[i].sel, rows[i].rst);
            bus(1'b1, rows[i].adr, rows[i].sel, rows[i].wdat);
            rdchk(rows[i].adr, rows[i].sel, rows[i].exp);
        end
        // Stopped counter keeps its value
        repeat (10) @(posedge clk_i);
        rdchk(18'h3fe18, 4'h3, 16'hbeef);
        // Level bit presets the pin before any match
        bus(1'b1, 18'h3fe04, 4'h1, 16'h0002);
        check({31'h0, pwm_output_pin_o}, 32'h1);
        bus(1'b1, 18'h3fe04, 4'h1, 16'h0000);
        check({31'h0, pwm_output_pin_o}, 32'h0);
        // PWM: period 4 clocks, high 3 of them
        bus(1'b1, 18'h3fe20, 4'h3, 16'h0003);
        bus(1'b1, 18'h3fe28, 4'h3, 16'h0002);
        bus(1'b1, 18'h3fe18, 4'h3, 16'h0000);
        bus(1'b1, 18'h3fe08, 4'h1, 16'h0000);
        bus(1'b1, 18'h3fe04, 4'h1, 16'h0082);
        bus(1'b1, 18'h3fe00, 4'h1, 16'h0081);
        repeat (300) @(posedge clk_i);
        measure(48);
        check(highs, 36);
        check(trans, 24);
        check({31'h0, level >= 8'ha0 && level <= 8'hd0}, 32'h1);
        bus(1'b0, 18'h3fe18, 4'h3, 16'h0000);
        check({31'h0, rd > 32'h3}, 32'h0);
        check({31'h0, irq_o}, 32'h0);
        rdchk(18'h3fe0c, 4'h1, 16'h0003);
        bus(1'b1, 18'h3fe08, 4'h1, 16'h0001);
        check({31'h0, irq_o}, 32'h1);
        bus(1'b1, 18'h3fe00, 4'h1, 16'h0001);
        bus(1'b1, 18'h3fe0c, 4'h1, 16'h0003);
        rdchk(18'h3fe0c, 4'h1, 16'h0000);
        check({31'h0, irq_o}, 32'h0);
        // Divide by two: period 8 clocks, high 6
        bus(1'b1, 18'h3fe18, 4'h3, 16'h0000);
        bus(1'b1, 18'h3fe04, 4'h1, 16'h0092);
        bus(1'b1, 18'h3fe00, 4'h1, 16'h0081);
        repeat (20) @(posedge clk_i);
        measure(48);
        check(highs, 36);
        check(trans, 12);
        // Compare output mode toggles once a period
        bus(1'b1, 18'h3fe04, 4'h1, 16'h0080);
        bus(1'b1, 18'h3fe00, 4'h1, 16'h0080);
        repeat (20) @(posedge clk_i);
        measure(48);
        check(highs, 24);
        check(trans, 12);
        // No clear: counter passes period and wraps at 16 bits
        bus(1'b1, 18'h3fe00, 4'h1, 16'h0000);
        bus(1'b1, 18'h3fe04, 4'h1, 16'h0000);
        bus(1'b1, 18'h3fe20, 4'h3, 16'h0005);
        bus(1'b1, 18'h3fe18, 4'h3, 16'hfff0);
        bus(1'b1, 18'h3fe00, 4'h1, 16'h0080);
        repeat (40) @(posedge clk_i);
        bus(1'b0, 18'h3fe18, 4'h3, 16'h0000);
        check({31'h0, rd > 32'h5 && rd < 32'h40}, 32'h1);
        // Second reset while running
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        check({30'h0, irq_o, pwm_output_pin_o}, 32'h0);
        rdchk(18'h3fe00, 4'h1, 16'(RST_MODE));
        rdchk(18'h3fe18, 4'h3, RST_COUNTER);
        close_out();
    end
endmodule : cmp_timer_tb
